/* hdl/hmc_pkg.sv */
// Register map and field layout of the holdover mode control block
package hmc_pkg;
  localparam int unsigned IDX_W         = 8;
  localparam logic [7:0]  IDX_FREQ_LOW  = 8'h3F;
  localparam logic [7:0]  IDX_FREQ_MID  = 8'h40;
  localparam logic [7:0]  IDX_MODE      = 8'h41;
  localparam logic [7:0]  RST_MODE      = 8'h88;
  localparam logic [7:0]  RST_FREQ_LOW  = 8'h00;
  localparam logic [7:0]  RST_FREQ_MID  = 8'h00;
  localparam int unsigned BIT_AUTO_AVG  = 7;
  localparam int unsigned BIT_FAST_AVG  = 6;
  localparam int unsigned BIT_READ_AVG  = 5;
  localparam int unsigned MINI_HI       = 4;
  localparam int unsigned MINI_LO       = 3;
  localparam int unsigned FTOP_HI       = 2;
  localparam int unsigned FREQ_W        = 19;
  localparam int unsigned FMID_LO       = 8;
  localparam int unsigned FTOP_LO       = 16;
  localparam logic [1:0]  MINI_AS_FULL  = 2'h0;
  localparam logic [1:0]  MINI_FROZEN   = 2'h1;
  localparam logic [1:0]  MINI_FAST     = 2'h2;
  localparam logic [1:0]  MINI_SLOW     = 2'h3;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
endpackage : hmc_pkg

/* hdl/hmc_ahb_front.sv */
// AHB-Lite address-phase capture for the holdover mode control block
`timescale 1ns/10ps
module hmc_ahb_front (
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic                     hready,
  output logic                          wrPend,
  output logic [hmc_pkg::IDX_W-1:0]     wrIdx,
  output wire logic                     rdTake,
  output wire logic [hmc_pkg::IDX_W-1:0] rdIdx
);
  import hmc_pkg::*;

  wire logic addrTake;
  wire logic inMap;

  // Only whole aligned words below the map ceiling hit a register
  assign inMap    = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0) && (hsize == HSIZE_WORD);
  assign addrTake = hsel && hready && (htrans == HTRANS_NONSEQ) && inMap;
  assign rdTake   = addrTake && !hwrite;
  assign rdIdx    = haddr[9:2];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend <= 1'b0;
      wrIdx  <= 8'h00;
    end else if (hready) begin
      wrPend <= addrTake && hwrite;
      wrIdx  <= haddr[9:2];
    end
  end
endmodule : hmc_ahb_front

/* hdl/hmc_holdover_ctrl.sv */
// Holdover mode control registers with AHB-Lite slave
//
// Summary of operation
// - Bit 7 selects averaged versus frozen holdover.
// - Bit 6 picks fast or slow averager.
// - Bit 5 low reads back written frequency.
// - Bit 5 high reads selected averaged frequency.
// - Bits 4:3 choose mini-holdover frequency source.
`timescale 1ns/10ps
module hmc_holdover_ctrl (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  input  wire logic                        manualEngaged,
  input  wire logic [hmc_pkg::FREQ_W-1:0]  avgFastFreq,
  input  wire logic [hmc_pkg::FREQ_W-1:0]  avgSlowFreq,
  output logic                             holdoverUseAvg,
  output logic                             holdoverFastAvg,
  output logic [1:0]                       miniHoldMode,
  output logic [hmc_pkg::FREQ_W-1:0]       holdoverFreqValue
);
  import hmc_pkg::*;

  logic [7:0]        modeCfg;
  logic [7:0]        freqMid;
  logic [7:0]        freqLow;
  logic              wrPend;
  logic [IDX_W-1:0]  wrIdx;
  wire logic              rdTake;
  wire logic [IDX_W-1:0]  rdIdx;
  wire logic [7:0]        next_modeCfg;
  wire logic [7:0]        next_freqMid;
  wire logic [7:0]        next_freqLow;
  wire logic [FREQ_W-1:0] freqWritten;
  wire logic [FREQ_W-1:0] avgSelected;
  wire logic [FREQ_W-1:0] freqRead;
  wire logic [7:0]        rdByte;
  // Bus decode, read path and loop-control next values
  wire logic              wrMode;
  wire logic              wrMid;
  wire logic              wrLow;
  wire logic              rdMode;
  wire logic              rdMid;
  wire logic              rdLow;
  wire logic [7:0]        wrByte;
  wire logic [7:0]        rdModeByte;
  wire logic [7:0]        rdMidByte;
  wire logic [7:0]        rdLowByte;
  wire logic [31:0]       rdWord;
  wire logic              next_holdoverUseAvg;
  wire logic              next_holdoverFastAvg;
  wire logic [1:0]        next_miniHoldMode;
  wire logic [FREQ_W-1:0] next_holdoverFreqValue;

  // Address phase is captured in the front end; this slave never stretches
  hmc_ahb_front hmc_ahb_front_inst (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .hsel   (hsel),
    .haddr  (haddr),
    .htrans (htrans),
    .hwrite (hwrite),
    .hsize  (hsize),
    .hready (hready),
    .wrPend (wrPend),
    .wrIdx  (wrIdx),
    .rdTake (rdTake),
    .rdIdx  (rdIdx)
  );

  // Writes decode in the data phase, reads in the address phase
  assign wrMode = wrPend && (wrIdx == IDX_MODE);
  assign wrMid  = wrPend && (wrIdx == IDX_FREQ_MID);
  assign wrLow  = wrPend && (wrIdx == IDX_FREQ_LOW);
  assign rdMode = (rdIdx == IDX_MODE);
  assign rdMid  = (rdIdx == IDX_FREQ_MID);
  assign rdLow  = (rdIdx == IDX_FREQ_LOW);

  // Only the low byte lane is used; upper lanes are dropped on purpose
  assign wrByte = hwdata[7:0];

  // A write replaces the whole byte; unwritten registers hold
  assign next_modeCfg = wrMode ? wrByte : modeCfg;
  assign next_freqMid = wrMid  ? wrByte : freqMid;
  assign next_freqLow = wrLow  ? wrByte : freqLow;

  // Reads see the post-write values so a read right after a write is fresh
  assign freqWritten = {next_modeCfg[FTOP_HI:0], next_freqMid, next_freqLow};
  assign avgSelected = next_modeCfg[BIT_FAST_AVG] ? avgFastFreq : avgSlowFreq;
  assign freqRead    = next_modeCfg[BIT_READ_AVG] ? avgSelected : freqWritten;

  // Mode bits 7:3 always read back as written; only the top value bits switch
  assign rdModeByte = {next_modeCfg[BIT_AUTO_AVG:MINI_LO], freqRead[FREQ_W-1:FTOP_LO]};
  assign rdMidByte  = freqRead[FTOP_LO-1:FMID_LO];
  assign rdLowByte  = freqRead[FMID_LO-1:0];

  // Unmapped indices read as zero but still answer OKAY
  assign rdByte = rdMode ? rdModeByte :
                  rdMid  ? rdMidByte  :
                  rdLow  ? rdLowByte  : 8'h00;
  assign rdWord = {24'h00_0000, rdByte};

  // Mode register wakes up with averaged holdover and frozen mini-holdover
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      modeCfg <= RST_MODE;
      freqMid <= RST_FREQ_MID;
      freqLow <= RST_FREQ_LOW;
    end else begin
      modeCfg <= next_modeCfg;
      freqMid <= next_freqMid;
      freqLow <= next_freqLow;
    end
  end

  // Zero-wait slave: read data is prepared during the address phase
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= rdTake ? rdWord : 32'h0000_0000;
    end
  end

  // Manual control overrides auto averaging in holdover
  assign next_holdoverUseAvg    = modeCfg[BIT_AUTO_AVG] && !manualEngaged;
  assign next_holdoverFastAvg   = modeCfg[BIT_FAST_AVG];
  assign next_miniHoldMode      = modeCfg[MINI_HI:MINI_LO];
  assign next_holdoverFreqValue = {modeCfg[FTOP_HI:0], freqMid, freqLow};

  // Loop controls lag the registers by one cycle so they leave a flip-flop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      holdoverUseAvg    <= 1'b0;
      holdoverFastAvg   <= 1'b0;
      miniHoldMode      <= MINI_AS_FULL;
      holdoverFreqValue <= '0;
    end else begin
      holdoverUseAvg    <= next_holdoverUseAvg;
      holdoverFastAvg   <= next_holdoverFastAvg;
      miniHoldMode      <= next_miniHoldMode;
      holdoverFreqValue <= next_holdoverFreqValue;
    end
  end

  a_auto_avg_sel: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrPend && wrIdx == IDX_MODE && !hwdata[BIT_AUTO_AVG]) |=> ##1 !holdoverUseAvg)
    else $error("holdover averaging not released after bit 7 cleared");

  a_fast_rate_sel: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(modeCfg[BIT_FAST_AVG]) |=> holdoverFastAvg == $past(modeCfg[BIT_FAST_AVG]))
    else $error("fast averager select does not follow bit 6");

  a_read_written: assert property (@(posedge mclk) disable iff (!rst_n)
    (rdTake && rdIdx == IDX_FREQ_LOW && !next_modeCfg[BIT_READ_AVG])
      |=> hrdata[7:0] == $past(next_freqLow))
    else $error("frequency read does not return written value");

  a_read_average: assert property (@(posedge mclk) disable iff (!rst_n)
    (rdTake && rdIdx == IDX_FREQ_MID && next_modeCfg[BIT_READ_AVG])
      |=> hrdata[7:0] == $past(avgSelected[15:8]))
    else $error("frequency read does not return averaged value");

  a_mini_hold_mode: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrPend && wrIdx == IDX_MODE) |=> ##1 miniHoldMode == $past(hwdata[MINI_HI:MINI_LO], 2))
    else $error("mini-holdover mode does not follow bits 4:3");

  a_freq_top_bits: assert property (@(posedge mclk) disable iff (!rst_n)
    (wrPend && wrIdx == IDX_MODE) |=> ##1 holdoverFreqValue[18:16] == $past(hwdata[FTOP_HI:0], 2))
    else $error("frequency top bits do not follow bits 2:0");

  // Antecedents sample rst_n so the release edge itself starts no attempt
  a_use_avg_manual: assert property (@(posedge mclk) disable iff (!rst_n)
    (rst_n && manualEngaged) |=> !holdoverUseAvg)
    else $error("manual control did not override averaged holdover");

  a_use_avg_auto: assert property (@(posedge mclk) disable iff (!rst_n)
    (rst_n && modeCfg[BIT_AUTO_AVG] && !manualEngaged) |=> holdoverUseAvg)
    else $error("averaged holdover not used with bit 7 set");

  a_read_slow_avg: assert property (@(posedge mclk) disable iff (!rst_n)
    (rdTake && rdLow && next_modeCfg[BIT_READ_AVG] && !next_modeCfg[BIT_FAST_AVG])
      |=> hrdata[7:0] == $past(avgSlowFreq[FMID_LO-1:0]))
    else $error("frequency read does not return slow averaged value");

  a_read_fast_avg: assert property (@(posedge mclk) disable iff (!rst_n)
    (rdTake && rdMode && next_modeCfg[BIT_READ_AVG] && next_modeCfg[BIT_FAST_AVG])
      |=> hrdata[FTOP_HI:0] == $past(avgFastFreq[FREQ_W-1:FTOP_LO]))
    else $error("top frequency bits do not return fast averaged value");

  a_read_written_mid: assert property (@(posedge mclk) disable iff (!rst_n)
    (rdTake && rdMid && !next_modeCfg[BIT_READ_AVG])
      |=> hrdata[7:0] == $past(next_freqMid))
    else $error("middle frequency read does not return written value");

  a_read_top_bits: assert property (@(posedge mclk) disable iff (!rst_n)
    (rdTake && rdMode && !next_modeCfg[BIT_READ_AVG])
      |=> hrdata[FTOP_HI:0] == $past(next_modeCfg[FTOP_HI:0]))
    else $error("top frequency bits do not read back as written");

  a_mode_readback: assert property (@(posedge mclk) disable iff (!rst_n)
    (rdTake && rdMode)
      |=> hrdata[BIT_AUTO_AVG:MINI_LO] == $past(next_modeCfg[BIT_AUTO_AVG:MINI_LO]))
    else $error("mode bits do not read back as written");

  a_value_mid: assert property (@(posedge mclk) disable iff (!rst_n)
    wrMid |=> ##1 holdoverFreqValue[FTOP_LO-1:FMID_LO] == $past(wrByte, 2))
    else $error("frequency value middle byte does not follow its write");

  a_value_low: assert property (@(posedge mclk) disable iff (!rst_n)
    wrLow |=> ##1 holdoverFreqValue[FMID_LO-1:0] == $past(wrByte, 2))
    else $error("frequency value low byte does not follow its write");
endmodule : hmc_holdover_ctrl

/* testbench/tb_holdover_mode_control.sv */
// Self-checking bench for the holdover mode control registers
`timescale 1ns/10ps
module tb_holdover_mode_control;
  import hmc_pkg::*;
  logic              mclk          = 1'b0;
  logic              rst_n         = 1'b0;
  logic              hsel          = 1'b0;
  logic [31:0]       haddr         = 32'h0;
  logic [1:0]        htrans        = 2'h0;
  logic              hwrite        = 1'b0;
  logic [2:0]        hsize         = HSIZE_WORD;
  logic [31:0]       hwdata        = 32'h0;
  logic              manualEngaged = 1'b0;
  logic [FREQ_W-1:0] avgFastFreq   = 19'h0;
  logic [FREQ_W-1:0] avgSlowFreq   = 19'h0;
  logic              hreadyout;
  logic              hresp;
  logic [31:0]       hrdata;
  logic              holdoverUseAvg;
  logic              holdoverFastAvg;
  logic [1:0]        miniHoldMode;
  logic [FREQ_W-1:0] holdoverFreqValue;
  logic [31:0]       seed          = 32'h8B2A;
  logic [31:0]       rd;
  logic [7:0]        mode;
  logic [7:0]        mid;
  logic [7:0]        low;
  int                nFail         = 0;
  int                totalChecks   = 0;

  hmc_holdover_ctrl hmc_holdover_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .manualEngaged(manualEngaged), .avgFastFreq(avgFastFreq), .avgSlowFreq(avgSlowFreq),
    .holdoverUseAvg(holdoverUseAvg), .holdoverFastAvg(holdoverFastAvg),
    .miniHoldMode(miniHoldMode), .holdoverFreqValue(holdoverFreqValue));

  always #4 mclk = ~mclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Averaged value replaces all three pieces when read-average is set
  function automatic logic [31:0] expRd(input logic [7:0] idx);
    logic [FREQ_W-1:0] f;
    f = mode[6] ? avgFastFreq : avgSlowFreq;
    if (!mode[5])
      f = {mode[2:0], mid, low};
    case (idx)
      IDX_FREQ_LOW: return {24'h0, f[7:0]};
      IDX_FREQ_MID: return {24'h0, f[15:8]};
      IDX_MODE:     return {24'h0, mode[7:3], f[18:16]};
      default:      return 32'h0;
    endcase
  endfunction : expRd

  task automatic testDone();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : testDone

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic waitReady();
    for (int i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (hreadyout === 1'b1)
        return;
    end
    nFail++;
    testDone();
  endtask : waitReady

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    waitReady();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    waitReady();
    rd = hrdata;
  endtask : bus

  task automatic checkAll();
    logic [7:0] idx [4];
    idx = '{IDX_FREQ_LOW, IDX_FREQ_MID, IDX_MODE, 8'hFF};
    chk(32'(holdoverUseAvg), 32'(mode[7] & ~manualEngaged));
    chk(32'(holdoverFastAvg), 32'(mode[6]));
    chk(32'(miniHoldMode), 32'(mode[4:3]));
    chk(32'(holdoverFreqValue), 32'({mode[2:0], mid, low}));
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, idx[i], 8'h00);
      chk(rd, expRd(idx[i]));
    end
    chk(32'(hresp), 32'h0);
  endtask : checkAll

  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    mode = RST_MODE;
    mid = RST_FREQ_MID;
    low = RST_FREQ_LOW;
    repeat (2) @(posedge mclk);
    checkAll();
    for (int n = 0; n < 24; n++) begin
      mode = 8'(rnd());
      // First passes walk every mini-holdover code
      if (n < 4)
        mode[4:3] = 2'(n);
      mid = 8'(rnd());
      low = 8'(rnd());
      manualEngaged <= 1'(rnd());
      avgFastFreq <= 19'(rnd());
      avgSlowFreq <= 19'(rnd());
      bus(1'b1, IDX_FREQ_LOW, low);
      bus(1'b1, IDX_FREQ_MID, mid);
      bus(1'b1, IDX_MODE, mode);
      repeat (3) @(posedge mclk);
      checkAll();
    end
    // Byte-sized write is refused and must leave the mode register alone
    hsize <= 3'h0;
    bus(1'b1, IDX_MODE, ~mode);
    hsize <= HSIZE_WORD;
    repeat (3) @(posedge mclk);
    checkAll();
    // Reset in mid-run clears the loop controls and restores register defaults
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(32'(holdoverUseAvg), 32'h0);
    chk(32'(holdoverFastAvg), 32'h0);
    chk(32'(miniHoldMode), 32'h0);
    chk(32'(holdoverFreqValue), 32'h0);
    chk(hrdata, 32'h0);
    chk(32'(hreadyout), 32'h1);
    rst_n <= 1'b1;
    mode = RST_MODE;
    mid = RST_FREQ_MID;
    low = RST_FREQ_LOW;
    repeat (2) @(posedge mclk);
    checkAll();
    testDone();
  end
endmodule : tb_holdover_mode_control
